/* logic/lechc_bank.sv */
// Functional notes
// RULE_01: lanes 3 to 5 each own an 8-bit register; bits 2:0 r/w, 7:3 read zero.
// RULE_02: hold bit set makes its counter stop at 0xFF until user reset.
// RULE_03: hold bit clear makes its counter roll over past 0xFF.
// RULE_04: bit 2 unexpected control char, bit 1 invalid code, bit 0 disparity.
// RULE_05: hold field of each lane reads 0x7 after reset.
// RULE_06: software writes hold fields only while deserializer core is in soft reset; the code still applies other writes and sets write_while_active_out.
// RULE_07: each counter is eight bits, up by one per error of its type.
`timescale 1ns/1ns
`default_nettype none
module lechc_bank
	import lechc_pkg::*;
(
	input  wire logic                                 clk_sys_in,
	input  wire logic                                 nrst_in,
	input  wire lechc_req_t                           req_in,
	output logic      [LECHC_DATA_W-1:0]              rdata_out,
	output logic                                      rvalid_out,
	input  wire logic                                 core_soft_reset_in,
	input  wire lechc_err_t [LECHC_LANES-1:0]         err_in,
	input  wire logic [LECHC_LANES-1:0][LECHC_KINDS-1:0] cnt_clear_in,
	output logic [LECHC_LANES-1:0][LECHC_KINDS-1:0][LECHC_CNT_W-1:0] count_out,
	output logic [LECHC_LANES-1:0][LECHC_KINDS-1:0]  lane_counter_saturate_enable_out,
	output logic                                      write_while_active_out
);
	typedef struct packed {
		logic [LECHC_LANES-1:0][LECHC_KINDS-1:0] hold;
		logic [LECHC_DATA_W-1:0]                 rdata;
		logic                                    rvalid;
		logic                                    bad_write;
	} lechc_state_t;

	lechc_state_t state;
	lechc_state_t next_state;
	logic [LECHC_LANES-1:0] sel;

	// address decode per lane
	assign sel[0] = req_in.addr == LECHC_OFS_LANE3;
	assign sel[1] = req_in.addr == LECHC_OFS_LANE4;
	assign sel[2] = req_in.addr == LECHC_OFS_LANE5;

	// register writes, read mux, sticky misuse flag
	always_comb begin
		next_state = state;
		next_state.rvalid = req_in.rd;
		if (req_in.rd) begin
			next_state.rdata = '0;
			for (int i = 0; i < LECHC_LANES; i++) begin
				if (sel[i]) begin
					next_state.rdata = {LECHC_RSVD_VALUE, state.hold[i]}; // RULE_01
				end
			end
		end
		if (req_in.wr) begin
			for (int i = 0; i < LECHC_LANES; i++) begin
				if (sel[i]) begin
					next_state.hold[i] = req_in.wdata[LECHC_KINDS-1:0]; // RULE_01
				end
			end
			if (|sel && !core_soft_reset_in) begin
				next_state.bad_write = 1'b1; // RULE_06
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			state.hold      <= {LECHC_LANES{LECHC_HOLD_RESET}}; // RULE_05
			state.rdata     <= '0;
			state.rvalid    <= 1'b0;
			state.bad_write <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	assign rdata_out                        = state.rdata;
	assign rvalid_out                       = state.rvalid;
	assign lane_counter_saturate_enable_out = state.hold;
	assign write_while_active_out           = state.bad_write;

	// one counter per lane and error kind; bit index picks the kind
	for (genvar l = 0; l < LECHC_LANES; l++) begin : g_lane
		logic [LECHC_KINDS-1:0] ev;
		assign ev[LECHC_BIT_UCC]  = err_in[l].unexpected_control_char_error; // RULE_04
		assign ev[LECHC_BIT_NIT]  = err_in[l].invalid_code_error;
		assign ev[LECHC_BIT_DISP] = err_in[l].disparity_error;
		for (genvar k = 0; k < LECHC_KINDS; k++) begin : g_kind
			lechc_counter u_cnt (
				.clk_sys_in (clk_sys_in),
				.nrst_in    (nrst_in),
				.hold_in    (state.hold[l][k]),
				.clear_in   (cnt_clear_in[l][k]),
				.event_in   (ev[k]),
				.count_out  (count_out[l][k])
			);

			// a clear on this counter empties it next cycle
			clear_wins_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_02
				cnt_clear_in[l][k]
				|=> count_out[l][k] == LECHC_CNT_ZERO)
				else $error("cleared counter not zero");

			// held counter parks at terminal value
			held_stop_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_02
				state.hold[l][k] && !cnt_clear_in[l][k] && count_out[l][k] == LECHC_TERMINAL
				|=> count_out[l][k] == LECHC_TERMINAL)
				else $error("held counter left terminal value");

			// free counter rolls over to zero
			free_wrap_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_03
				!state.hold[l][k] && !cnt_clear_in[l][k] && ev[k]
				&& count_out[l][k] == LECHC_TERMINAL
				|=> count_out[l][k] == LECHC_CNT_ZERO)
				else $error("free counter did not roll over");

			// counters start empty after reset
			count_reset_a: assert property (@(posedge clk_sys_in) // RULE_07
				!nrst_in
				|=> count_out[l][k] == LECHC_CNT_ZERO)
				else $error("counter not zero after reset");
		end

		// a write to this lane lands in its hold field
		lane_write_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_01
			req_in.wr && sel[l]
			|=> lane_counter_saturate_enable_out[l] == $past(req_in.wdata[LECHC_KINDS-1:0]))
			else $error("lane hold field not written");

		// a read of this lane returns the old field, upper bits zero
		lane_read_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_01
			req_in.rd && sel[l]
			|=> rdata_out == {LECHC_RSVD_VALUE, $past(state.hold[l])})
			else $error("lane readback wrong");

		// control char error steps the bit 2 counter
		ucc_map_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_04
			err_in[l].unexpected_control_char_error && !cnt_clear_in[l][LECHC_BIT_UCC]
			&& count_out[l][LECHC_BIT_UCC] != LECHC_TERMINAL
			|=> count_out[l][LECHC_BIT_UCC] == $past(count_out[l][LECHC_BIT_UCC]) + LECHC_CNT_ONE)
			else $error("control char error drove wrong counter");

		// invalid code error steps the bit 1 counter
		nit_map_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_04
			err_in[l].invalid_code_error && !cnt_clear_in[l][LECHC_BIT_NIT]
			&& count_out[l][LECHC_BIT_NIT] != LECHC_TERMINAL
			|=> count_out[l][LECHC_BIT_NIT] == $past(count_out[l][LECHC_BIT_NIT]) + LECHC_CNT_ONE)
			else $error("invalid code error drove wrong counter");

		// disparity error steps the bit 0 counter
		disp_map_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_04
			err_in[l].disparity_error && !cnt_clear_in[l][LECHC_BIT_DISP]
			&& count_out[l][LECHC_BIT_DISP] != LECHC_TERMINAL
			|=> count_out[l][LECHC_BIT_DISP] == $past(count_out[l][LECHC_BIT_DISP]) + LECHC_CNT_ONE)
			else $error("disparity error drove wrong counter");
	end

	rsvd_zero_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_01
		req_in.rd |=> rvalid_out && rdata_out[LECHC_DATA_W-1:LECHC_KINDS] == '0)
		else $error("reserved bits not zero");
	write_read_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_01
		req_in.wr && sel[1] && !req_in.rd ##1 !req_in.wr ##1 req_in.rd && sel[1] && !req_in.wr
		|=> rdata_out[LECHC_KINDS-1:0] == $past(req_in.wdata[LECHC_KINDS-1:0], 3))
		else $error("hold field readback mismatch");
	reset_value_a: assert property (@(posedge clk_sys_in) // RULE_05
		!nrst_in |=> state.hold == {LECHC_LANES{LECHC_HOLD_RESET}})
		else $error("hold field not 0x7 after reset");
	misuse_flag_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_06
		req_in.wr && |sel && !core_soft_reset_in |=> write_while_active_out)
		else $error("active-time write not flagged");
	hold_map_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_04
		!cnt_clear_in[0][LECHC_BIT_UCC] && err_in[0].unexpected_control_char_error
		&& count_out[0][LECHC_BIT_UCC] != LECHC_TERMINAL
		|=> count_out[0][LECHC_BIT_UCC] == $past(count_out[0][LECHC_BIT_UCC]) + LECHC_CNT_ONE)
		else $error("control char error drove wrong counter");

	// read valid is a single pulse after a read
	rvalid_pulse_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_01
		!req_in.rd
		|=> !rvalid_out)
		else $error("read valid without a read");

	// unmapped reads return zero
	unmapped_read_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_01
		req_in.rd && !(|sel)
		|=> rdata_out == '0)
		else $error("unmapped read not zero");

	// unmapped writes leave every hold field alone
	unmapped_write_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_01
		req_in.wr && !(|sel)
		|=> $stable(lane_counter_saturate_enable_out))
		else $error("unmapped write changed a hold field");

	// hold fields move only on a write
	hold_quiet_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_01
		!req_in.wr
		|=> $stable(lane_counter_saturate_enable_out))
		else $error("hold field moved without a write");

	// read data stands until the next read
	rdata_keep_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_01
		!req_in.rd
		|=> $stable(rdata_out))
		else $error("read data changed without a read");

	// misuse flag is sticky until reset
	flag_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_06
		write_while_active_out
		|=> write_while_active_out)
		else $error("misuse flag dropped");

	// legal writes never raise the misuse flag
	flag_quiet_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_06
		!write_while_active_out && !(req_in.wr && |sel && !core_soft_reset_in)
		|=> !write_while_active_out)
		else $error("misuse flag raised by a legal write");

	// bus outputs are quiet after reset
	reset_bus_a: assert property (@(posedge clk_sys_in) // RULE_05
		!nrst_in
		|=> rdata_out == '0 && !rvalid_out && !write_while_active_out)
		else $error("bus outputs not idle after reset");
endmodule
`default_nettype wire

/* logic/lechc_counter.sv */
`timescale 1ns/1ns
`default_nettype none
module lechc_counter
	import lechc_pkg::*;
(
	input  wire logic                   clk_sys_in,
	input  wire logic                   nrst_in,
	input  wire logic                   hold_in,
	input  wire logic                   clear_in,
	input  wire logic                   event_in,
	output logic      [LECHC_CNT_W-1:0] count_out
);
	typedef struct packed {
		logic [LECHC_CNT_W-1:0] count;
	} lechc_cnt_state_t;

	lechc_cnt_state_t state;
	lechc_cnt_state_t next_state;

	// count one per error; stop at terminal or roll over
	always_comb begin
		next_state = state;
		if (clear_in) begin
			next_state.count = LECHC_CNT_ZERO;
		end else if (event_in) begin
			if (hold_in && state.count == LECHC_TERMINAL) begin
				next_state.count = state.count; // RULE_02
			end else begin
				next_state.count = state.count + LECHC_CNT_ONE; // RULE_03 RULE_07
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign count_out = state.count;

	saturate_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_02
		hold_in && !clear_in && state.count == LECHC_TERMINAL |=> state.count == LECHC_TERMINAL)
		else $error("held counter left terminal value");
	wrap_around_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_03
		!hold_in && !clear_in && event_in && state.count == LECHC_TERMINAL
		|=> state.count == LECHC_CNT_ZERO)
		else $error("free counter did not wrap");
	count_step_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_07
		!clear_in && event_in && state.count != LECHC_TERMINAL
		|=> state.count == $past(state.count) + LECHC_CNT_ONE)
		else $error("counter did not step by one");
	count_idle_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE_07
		!clear_in && !event_in |=> $stable(state.count))
		else $error("counter moved without an error");
endmodule
`default_nettype wire

/* logic/lechc_pkg.sv */
`default_nettype none
package lechc_pkg;
	// register map and field layout
	localparam int          LECHC_LANES      = 3;
	localparam int          LECHC_KINDS      = 3;
	localparam int          LECHC_CNT_W      = 8;
	localparam int          LECHC_ADDR_W     = 12;
	localparam int          LECHC_DATA_W     = 8;
	localparam logic [11:0] LECHC_OFS_LANE3  = 12'h048b;
	localparam logic [11:0] LECHC_OFS_LANE4  = 12'h048c;
	localparam logic [11:0] LECHC_OFS_LANE5  = 12'h048d;
	localparam logic [2:0]  LECHC_HOLD_RESET = 3'h7;
	localparam logic [4:0]  LECHC_RSVD_VALUE = 5'h00;
	localparam logic [7:0]  LECHC_TERMINAL   = 8'hff;
	localparam logic [7:0]  LECHC_CNT_ONE    = 8'h01;
	localparam logic [7:0]  LECHC_CNT_ZERO   = 8'h00;
	// bit positions inside a hold field
	localparam int          LECHC_BIT_UCC    = 2;
	localparam int          LECHC_BIT_NIT    = 1;
	localparam int          LECHC_BIT_DISP   = 0;

	// register bus request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} lechc_req_t;

	// per-lane error events, bit order as in the hold field
	typedef struct packed {
		logic unexpected_control_char_error;
		logic invalid_code_error;
		logic disparity_error;
	} lechc_err_t;
endpackage
`default_nettype wire

/* tb/lane_error_counter_hold_cfg_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module lane_error_counter_hold_cfg_bench
	import lechc_pkg::*;
();
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	lechc_req_t req;
	logic core_srst, rvalid, flag;
	logic [7:0] rdata;
	lechc_err_t [2:0] err = '0;
	logic [2:0][2:0] clr = '0;
	logic [2:0][2:0] sat;
	logic [2:0][2:0][7:0] count;
	int bad_count = 0;
	int num_checks = 0;
	int cyc = 0;
	// clock, 100 ns period
	always #50 clk_sys_in = ~clk_sys_in;
	lechc_host host (.clk_sys_in(clk_sys_in), .req_out(req), .core_soft_reset_out(core_srst));
	lechc_bank DUT (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .req_in(req), .rdata_out(rdata),
		.rvalid_out(rvalid), .core_soft_reset_in(core_srst), .err_in(err), .cnt_clear_in(clr),
		.count_out(count), .lane_counter_saturate_enable_out(sat), .write_while_active_out(flag));
	// verdict and end of run
	task automatic close_out();
		if (bad_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			close_out();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [11:0] a);
		host.access(1'b0, a, 8'h00);
		#1;
		chk({7'h0, rvalid}, 8'h01);
	endtask
	// reset values of all three lanes
	task automatic t_reset();
		for (int i = 0; i < 3; i++) begin
			rd(LECHC_OFS_LANE3 + 12'(i));
			chk(rdata, 8'h07);
		end
		chk({7'h0, sat == 9'h1ff}, 8'h01);
	endtask
	// reserved bits, field mapping, unmapped read
	task automatic t_rw();
		host.access(1'b1, LECHC_OFS_LANE4, 8'hfa);
		rd(LECHC_OFS_LANE4);
		chk(rdata, 8'h02);
		chk({5'h0, sat[1]}, 8'h02);
		rd(12'h048e);
		chk(rdata, 8'h00);
		host.access(1'b1, 12'h048e, 8'h05);
		#1;
		chk({5'h0, sat[1]}, 8'h02);
	endtask
	// 257 errors: held kind stops at ff, others wrap to 01
	task automatic t_count();
		host.access(1'b1, LECHC_OFS_LANE3, 8'h04);
		repeat (257) begin
			@(posedge clk_sys_in);
			err[0] <= lechc_err_t'(3'h7);
		end
		@(posedge clk_sys_in);
		err[0] <= '0;
		@(posedge clk_sys_in);
		#1;
		chk(count[0][2], 8'hff);
		chk(count[0][1], 8'h01);
		chk(count[0][0], 8'h01);
		chk(count[1][2], 8'h00);
		@(posedge clk_sys_in);
		clr[0][2] <= 1'b1;
		@(posedge clk_sys_in);
		clr[0][2] <= 1'b0;
		#1;
		chk(count[0][2], 8'h00);
	endtask
	// write while the core runs raises the misuse flag
	task automatic t_misuse();
		chk({7'h0, flag}, 8'h00);
		host.core(1'b0);
		host.access(1'b1, LECHC_OFS_LANE5, 8'h01);
		#1;
		chk({7'h0, flag}, 8'h01);
	endtask
	// reset, then the scenarios
	initial begin
		repeat (4) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		t_reset();
		t_rw();
		t_count();
		t_misuse();
		close_out();
	end
endmodule
`default_nettype wire

/* tb/lechc_host.sv */
`timescale 1ns/1ns
`default_nettype none
module lechc_host
	import lechc_pkg::*;
(
	input  wire logic       clk_sys_in,
	output var  lechc_req_t req_out,
	output var  logic       core_soft_reset_out
);
	// idle bus, core parked in soft reset so writes are legal
	initial begin
		req_out = '0;
		core_soft_reset_out = 1'b1;
	end
	// one register cycle; strobes drop to zero, address and data show the inverse of the last value
	task automatic access(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		req_out <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk_sys_in);
		req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// leave or enter soft reset of the core
	task automatic core(input logic v);
		@(posedge clk_sys_in);
		core_soft_reset_out <= v;
	endtask
endmodule
`default_nettype wire
